// File: hw/dpbr_array.v
// Shared 18-Kbit storage array with two masked write ports.
`timescale 1ns/10ps
`include "dpbr_regs.vh"

module dpbr_array
#(
   parameter [`DPBR_ARRAY_BITS-1:0] MEMORY_PRELOAD_VALUES =
      {`DPBR_ARRAY_BITS{1'b0}}
)
(
   input  wire                      clk_i,
   input  wire                      a_we_i,
   input  wire [`DPBR_INDEX_W-1:0]  a_idx_i,
   input  wire [`DPBR_WORD_W-1:0]   a_mask_i,
   input  wire [`DPBR_WORD_W-1:0]   a_word_i,
   input  wire                      b_we_i,
   input  wire [`DPBR_INDEX_W-1:0]  b_idx_i,
   input  wire [`DPBR_WORD_W-1:0]   b_mask_i,
   input  wire [`DPBR_WORD_W-1:0]   b_word_i,
   output wire [`DPBR_WORD_W-1:0]   a_rd_o,
   output wire [`DPBR_WORD_W-1:0]   b_rd_o
);

   reg [`DPBR_WORD_W-1:0] mem [0:`DPBR_WORDS-1];
   integer i;

   // Start-up content from the preload vector, word 0 in the low bits
   initial
   begin
      for (i = 0; i < `DPBR_WORDS; i = i + 1)
         mem[i] = MEMORY_PRELOAD_VALUES[i*`DPBR_WORD_W +: `DPBR_WORD_W];
   end

   // Reads see the content before this edge's writes
   assign a_rd_o = mem[a_idx_i];
   assign b_rd_o = mem[b_idx_i];

   // Both ports may touch different bits of one word in the same
   // cycle, so a shared word is merged rather than overwritten
   always @(posedge clk_i)
   begin
      if (a_we_i && b_we_i && (a_idx_i == b_idx_i))
         mem[a_idx_i] <= (mem[a_idx_i] & ~(a_mask_i | b_mask_i)) |
                         (a_word_i & a_mask_i) | (b_word_i & b_mask_i);
      else
      begin
         if (a_we_i)
            mem[a_idx_i] <= (mem[a_idx_i] & ~a_mask_i) |
                            (a_word_i & a_mask_i);
         if (b_we_i)
            mem[b_idx_i] <= (mem[b_idx_i] & ~b_mask_i) |
                            (b_word_i & b_mask_i);
      end
   end

endmodule // dpbr_array

// File: hw/dpbr_regs.vh
// Constants for the dual-port block RAM: geometry, modes, inversion bits.
`ifndef DPBR_REGS_VH
`define DPBR_REGS_VH

// Shared array geometry: 512 words of 32 data plus 4 parity bits
`define DPBR_ARRAY_BITS   18432
`define DPBR_WORDS        512
`define DPBR_WORD_W       36
`define DPBR_INDEX_W      9
`define DPBR_ADDR_W       14
`define DPBR_DATA_W       32
`define DPBR_PAR_W        4

// Write-time behaviour of the output register
`define DPBR_MODE_PASS_NEW 2'h0
`define DPBR_MODE_OLD_DATA 2'h1
`define DPBR_MODE_HOLD     2'h2

// Bit positions in a port's inversion vector
`define DPBR_INV_CLK      0
`define DPBR_INV_GATE     1
`define DPBR_INV_STROBE   2
`define DPBR_INV_PRESET   3

// Reset values and timing
`define DPBR_OUT_INIT_RST 36'h000000000
`define DPBR_PRESET_RST   36'h000000000
`define DPBR_INV_RST      4'h0
`define DPBR_ARM_CYCLES   3

`endif

// File: hw/dpbr_top.v
// True dual-port block RAM: two port controllers around a shared array.
//
// Overview of operation
// - Two independent ports share one 18-Kbit array
// - Each port picks its own data width
// - Widths 1,2,4,9,18,36 with matching depths
// - Enabled edge loads addressed word into output
// - Enabled edge with strobe stores the data
// - Active clock edge rising or falling per port
// - Writes also read, except in hold mode or with preset; three output modes
// - Pass-new mode outputs the word just written
// - Old-data mode outputs content before the write
// - Hold mode: only plain reads and presets change output
// - Each control input has optional polarity inversion
// - Gate off (low unless inverted): no read, write or preset
// - Preset with gate loads per-port preset value
// - Array preload and output initial value configurable
// - Initial and preset values independent per port
// - Wide ports reach parity; narrow reach data only
`timescale 1ns/10ps
`include "dpbr_regs.vh"

module dpbr_top
#(
   parameter integer PORT_A_WIDTH = 36,
   parameter integer PORT_B_WIDTH = 36,
   parameter [1:0]   PORT_A_MODE  = `DPBR_MODE_PASS_NEW,
   parameter [1:0]   PORT_B_MODE  = `DPBR_MODE_PASS_NEW,
   parameter [3:0]   PORT_A_INVERT = `DPBR_INV_RST,
   parameter [3:0]   PORT_B_INVERT = `DPBR_INV_RST,
   parameter [35:0]  PORT_A_INIT_VALUE   = `DPBR_OUT_INIT_RST,
   parameter [35:0]  PORT_B_INIT_VALUE   = `DPBR_OUT_INIT_RST,
   parameter [35:0]  PORT_A_PRESET_VALUE = `DPBR_PRESET_RST,
   parameter [35:0]  PORT_B_PRESET_VALUE = `DPBR_PRESET_RST,
   parameter [`DPBR_ARRAY_BITS-1:0] MEMORY_PRELOAD_VALUES =
      {`DPBR_ARRAY_BITS{1'b0}}
)
(
   input  wire        clk_i,
   input  wire        reset_n_i,
   input  wire        port_a_clk_i,
   input  wire        port_a_gate,
   input  wire        port_a_store_strobe,
   input  wire        port_a_sync_output_preset_i,
   input  wire [13:0] port_a_addr_i,
   input  wire [31:0] port_a_write_in_word_i,
   input  wire [3:0]  port_a_write_in_parity_i,
   output wire [31:0] port_a_read_word_o,
   output wire [3:0]  port_a_read_parity_o,
   input  wire        port_b_clk_i,
   input  wire        port_b_gate,
   input  wire        port_b_store_strobe,
   input  wire        port_b_sync_output_preset_i,
   input  wire [13:0] port_b_addr_i,
   input  wire [31:0] port_b_write_in_word_i,
   input  wire [3:0]  port_b_write_in_parity_i,
   output wire [31:0] port_b_read_word_o,
   output wire [3:0]  port_b_read_parity_o
);

   // Word index inside the 512-word array for a given port width
   function [8:0] f_index;
      input integer w;
      input [13:0]  a;
      begin
         case (w)
            1:       f_index = a[13:5];
            2:       f_index = a[12:4];
            4:       f_index = a[11:3];
            9:       f_index = a[10:2];
            18:      f_index = a[9:1];
            default: f_index = a[8:0];
         endcase
      end
   endfunction

   // Places port data {parity,data} at its bit lane in a 36-bit word;
   // called with all ones it yields the write mask
   function [35:0] f_place;
      input integer w;
      input [13:0]  a;
      input [35:0]  d;
      reg   [5:0]   sh;
      reg   [5:0]   ps;
      begin
         sh = 6'h00;
         ps = 6'h20;
         case (w)
            1:
            begin
               sh = {1'b0, a[4:0]};
               f_place = {35'h0, d[0]} << sh;
            end
            2:
            begin
               sh = {1'b0, a[3:0], 1'b0};
               f_place = {34'h0, d[1:0]} << sh;
            end
            4:
            begin
               sh = {1'b0, a[2:0], 2'h0};
               f_place = {32'h0, d[3:0]} << sh;
            end
            9:
            begin
               sh = {1'b0, a[1:0], 3'h0};
               ps = {4'h8, a[1:0]};
               f_place = ({28'h0, d[7:0]} << sh) | ({35'h0, d[32]} << ps);
            end
            18:
            begin
               sh = {1'b0, a[0], 4'h0};
               ps = {4'h8, a[0], 1'b0};
               f_place = ({20'h0, d[15:0]} << sh) |
                         ({34'h0, d[33:32]} << ps);
            end
            default: f_place = d;
         endcase
      end
   endfunction

   // Pulls a port's lane back out of a word, right-aligned, parity on top
   function [35:0] f_extract;
      input integer w;
      input [13:0]  a;
      input [35:0]  word;
      reg   [35:0]  t;
      reg   [35:0]  u;
      begin
         t = 36'h0;
         u = 36'h0;
         case (w)
            1:
            begin
               t = word >> {1'b0, a[4:0]};
               f_extract = {35'h0, t[0]};
            end
            2:
            begin
               t = word >> {1'b0, a[3:0], 1'b0};
               f_extract = {34'h0, t[1:0]};
            end
            4:
            begin
               t = word >> {1'b0, a[2:0], 2'h0};
               f_extract = {32'h0, t[3:0]};
            end
            9:
            begin
               t = word >> {1'b0, a[1:0], 3'h0};
               u = word >> {4'h8, a[1:0]};
               f_extract = {3'h0, u[0], 24'h0, t[7:0]};
            end
            18:
            begin
               t = word >> {1'b0, a[0], 4'h0};
               u = word >> {4'h8, a[0], 1'b0};
               f_extract = {2'h0, u[1:0], 16'h0, t[15:0]};
            end
            default: f_extract = word;
         endcase
      end
   endfunction

   // Both ports side by side, port A in the low slice
   wire [1:0]  clk_pin  = {port_b_clk_i, port_a_clk_i};
   wire [1:0]  gate_pin = {port_b_gate, port_a_gate};
   wire [1:0]  strb_pin = {port_b_store_strobe, port_a_store_strobe};
   wire [1:0]  pre_pin  = {port_b_sync_output_preset_i,
                           port_a_sync_output_preset_i};
   wire [27:0] addr_all = {port_b_addr_i, port_a_addr_i};
   wire [71:0] din_all  = {port_b_write_in_parity_i, port_b_write_in_word_i,
                           port_a_write_in_parity_i, port_a_write_in_word_i};
   wire [1:0]  we_w;
   wire [17:0] idx_w;
   wire [71:0] mask_w;
   wire [71:0] wword_w;
   wire [71:0] rd_w;
   wire [71:0] out_w;

   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1)
      begin : g_port
         localparam integer W    = p ? PORT_B_WIDTH : PORT_A_WIDTH;
         localparam [1:0]   MODE = p ? PORT_B_MODE : PORT_A_MODE;
         localparam [3:0]   INV  = p ? PORT_B_INVERT : PORT_A_INVERT;
         localparam [35:0]  INIT = p ? PORT_B_INIT_VALUE
                                     : PORT_A_INIT_VALUE;
         localparam [35:0]  PRE  = p ? PORT_B_PRESET_VALUE
                                     : PORT_A_PRESET_VALUE;

         reg        clk_s1_reg;
         reg        clk_s2_reg;
         reg        clk_prev_reg;
         reg [2:0]  arm_reg;
         reg [35:0] out_reg;
         reg [35:0] out_next;

         wire [13:0] addr = addr_all[14*p +: 14];
         wire [35:0] din  = din_all[36*p +: 36];
         wire [35:0] rd   = rd_w[36*p +: 36];
         // Polarity inversion applied before any use
         wire gate_on = gate_pin[p] ^ INV[`DPBR_INV_GATE];
         wire strb_on = strb_pin[p] ^ INV[`DPBR_INV_STROBE];
         wire pre_on  = pre_pin[p] ^ INV[`DPBR_INV_PRESET];
         // Rising edge normally, falling edge when the clock is inverted
         wire rise    = clk_s2_reg & ~clk_prev_reg;
         wire fall    = clk_prev_reg & ~clk_s2_reg;
         wire act     = arm_reg[2] &
                        (INV[`DPBR_INV_CLK] ? fall : rise);
         wire fire    = act & gate_on;
         wire [35:0] mask = f_place(W, addr, {36{1'b1}});
         wire [35:0] wwd  = f_place(W, addr, din);
         wire [35:0] merged = (rd & ~mask) | (wwd & mask);

         assign we_w[p]              = fire & strb_on;
         assign idx_w[9*p +: 9]      = f_index(W, addr);
         assign mask_w[36*p +: 36]   = mask;
         assign wword_w[36*p +: 36]  = wwd;
         assign out_w[36*p +: 36]    = out_reg;

         // Output register source: preset wins, then write mode, then read
         always @*
         begin
            out_next = out_reg;
            if (fire)
            begin
               if (pre_on)
                  out_next = PRE;
               else if (strb_on)
               begin
                  case (MODE)
                     `DPBR_MODE_PASS_NEW:
                        out_next = f_extract(W, addr, merged);
                     `DPBR_MODE_OLD_DATA:
                        out_next = f_extract(W, addr, rd);
                     `DPBR_MODE_HOLD:
                        out_next = out_reg;
                     default:
                        out_next = out_reg;
                  endcase
               end
               else
                  out_next = f_extract(W, addr, rd);
            end
         end

         // Port clock arrives from outside; two flops before edge detect.
         // Arming suppresses a false edge while the pipeline refills.
         always @(posedge clk_i)
         begin
            if (!reset_n_i)
            begin
               clk_s1_reg   <= 1'b0;
               clk_s2_reg   <= 1'b0;
               clk_prev_reg <= 1'b0;
               arm_reg      <= 3'h0;
               out_reg      <= INIT;
            end
            else
            begin
               clk_s1_reg   <= clk_pin[p];
               clk_s2_reg   <= clk_s1_reg;
               clk_prev_reg <= clk_s2_reg;
               arm_reg      <= {arm_reg[1:0], 1'b1};
               out_reg      <= out_next;
            end
         end
      end
   endgenerate

   // One shared storage array for both ports
   dpbr_array
   #(
      .MEMORY_PRELOAD_VALUES (MEMORY_PRELOAD_VALUES)
   )
   u_array
   (
      .clk_i    (clk_i),
      .a_we_i   (we_w[0]),
      .a_idx_i  (idx_w[8:0]),
      .a_mask_i (mask_w[35:0]),
      .a_word_i (wword_w[35:0]),
      .b_we_i   (we_w[1]),
      .b_idx_i  (idx_w[17:9]),
      .b_mask_i (mask_w[71:36]),
      .b_word_i (wword_w[71:36]),
      .a_rd_o   (rd_w[35:0]),
      .b_rd_o   (rd_w[71:36])
   );

   assign port_a_read_word_o   = out_w[31:0];
   assign port_a_read_parity_o = out_w[35:32];
   assign port_b_read_word_o   = out_w[67:36];
   assign port_b_read_parity_o = out_w[71:68];

endmodule // dpbr_top

// File: verif/dpbr_top_assertions.sv
// Checker on the port behaviour of the dual-port RAM top.
`timescale 1ns/10ps
module dpbr_top_checker
#(
   parameter [3:0]  PORT_A_INVERT       = 4'h0,
   parameter [3:0]  PORT_B_INVERT       = 4'h0,
   parameter [1:0]  PORT_B_MODE         = 2'h0,
   parameter [35:0] PORT_A_INIT_VALUE   = 36'h000000000,
   parameter [35:0] PORT_B_INIT_VALUE   = 36'h000000000,
   parameter [35:0] PORT_A_PRESET_VALUE = 36'h000000000,
   parameter [35:0] PORT_B_PRESET_VALUE = 36'h000000000
)
(
   input wire        clk_i,
   input wire        reset_n_i,
   input wire        port_a_clk_i,
   input wire        port_a_gate,
   input wire        port_a_store_strobe,
   input wire        port_a_sync_output_preset_i,
   input wire [31:0] port_a_read_word_o,
   input wire [3:0]  port_a_read_parity_o,
   input wire        port_b_clk_i,
   input wire        port_b_gate,
   input wire        port_b_store_strobe,
   input wire        port_b_sync_output_preset_i,
   input wire [31:0] port_b_read_word_o,
   input wire [3:0]  port_b_read_parity_o
);
   logic [2:0] a_pin_reg;
   logic [2:0] b_pin_reg;
   wire [35:0] a_out = {port_a_read_parity_o, port_a_read_word_o};
   wire [35:0] b_out = {port_b_read_parity_o, port_b_read_word_o};
   wire        a_go  = port_a_gate ^ PORT_A_INVERT[1];
   wire        b_go  = port_b_gate ^ PORT_B_INVERT[1];
   wire        a_ps  = port_a_sync_output_preset_i ^ PORT_A_INVERT[3];
   wire        b_ps  = port_b_sync_output_preset_i ^ PORT_B_INVERT[3];
   wire        b_st  = port_b_store_strobe ^ PORT_B_INVERT[2];
   // Active edge as the design sees it, after its pin sampler
   wire        a_ev  = (a_pin_reg[1] ^ PORT_A_INVERT[0])
                       & ~(a_pin_reg[2] ^ PORT_A_INVERT[0]);
   wire        b_ev  = (b_pin_reg[1] ^ PORT_B_INVERT[0])
                       & ~(b_pin_reg[2] ^ PORT_B_INVERT[0]);

   // Pin history mirrors the two sync flops plus the edge compare
   always @(posedge clk_i)
   begin
      a_pin_reg <= {a_pin_reg[1:0], port_a_clk_i};
      b_pin_reg <= {b_pin_reg[1:0], port_b_clk_i};
   end

   default clocking dpbr_cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   a_init_val_a: assert property ($rose(reset_n_i) |-> a_out == PORT_A_INIT_VALUE) else $error("port a init wrong");
   a_init_val_b: assert property ($rose(reset_n_i) |-> b_out == PORT_B_INIT_VALUE) else $error("port b init wrong");
   a_edge_only_a: assert property ($changed(a_out) |-> $past(a_ev)) else $error("port a output moved off edge");
   a_edge_only_b: assert property ($changed(b_out) |-> $past(b_ev)) else $error("port b output moved off edge");
   a_gate_off_a: assert property ($changed(a_out) |-> $past(a_go)) else $error("port a output moved while gated");
   a_gate_off_b: assert property ($changed(b_out) |-> $past(b_go)) else $error("port b output moved while gated");
   a_preset_val_a: assert property (a_ev && a_go && a_ps |=> a_out == PORT_A_PRESET_VALUE) else $error("port a preset wrong");
   a_preset_val_b: assert property (b_ev && b_go && b_ps |=> b_out == PORT_B_PRESET_VALUE) else $error("port b preset wrong");
   a_hold_write_b: assert property (PORT_B_MODE == 2'h2 && b_ev && b_go && b_st && !b_ps |=> $stable(b_out)) else $error("port b output changed on write");

   c_preset_a: cover property (a_ev && a_go && a_ps);
   c_hold_b: cover property (b_ev && b_go && b_st && !b_ps);
   c_gate_off_a: cover property (a_ev && !a_go);
endmodule // dpbr_top_checker

bind dpbr_top dpbr_top_checker
#(
   .PORT_A_INVERT(PORT_A_INVERT),
   .PORT_B_INVERT(PORT_B_INVERT),
   .PORT_B_MODE(PORT_B_MODE),
   .PORT_A_INIT_VALUE(PORT_A_INIT_VALUE),
   .PORT_B_INIT_VALUE(PORT_B_INIT_VALUE),
   .PORT_A_PRESET_VALUE(PORT_A_PRESET_VALUE),
   .PORT_B_PRESET_VALUE(PORT_B_PRESET_VALUE)
)
u_chk
(
   .clk_i, .reset_n_i, .port_a_clk_i, .port_a_gate, .port_a_store_strobe,
   .port_a_sync_output_preset_i, .port_a_read_word_o, .port_a_read_parity_o,
   .port_b_clk_i, .port_b_gate, .port_b_store_strobe,
   .port_b_sync_output_preset_i, .port_b_read_word_o, .port_b_read_parity_o
);

// File: verif/dpbr_user_port.sv
// User-logic model that drives one port of the dual-port RAM.
`timescale 1ns/10ps
module dpbr_user_port
#(
   parameter [3:0] INV = 4'h0
)
(
   input  wire          clk_i,
   output logic         pclk_o,
   output logic         gate_o,
   output logic         strobe_o,
   output logic         preset_o,
   output logic [13:0]  addr_o,
   output logic [35:0]  data_o
);
   // Idle: port clock at its inactive level, gate off
   initial
   begin
      pclk_o   = INV[0];
      gate_o   = INV[1];
      strobe_o = INV[2];
      preset_o = INV[3];
      addr_o   = 14'h0000;
      data_o   = 36'h000000000;
   end

   // First pin edge is the active one; inputs held over both phases
   // because the edge is only seen three system cycles later
   task access(input logic en, we, pre, input logic [13:0] addr,
               input logic [35:0] d);
      @(negedge clk_i);
      gate_o   = en ^ INV[1];
      strobe_o = we ^ INV[2];
      preset_o = pre ^ INV[3];
      addr_o   = addr;
      data_o   = d; // Parity travels as plain data
      pclk_o   = ~INV[0];
      repeat (4) @(negedge clk_i);
      pclk_o   = INV[0];
      repeat (4) @(negedge clk_i);
      // Released lines must not keep their last value
      gate_o   = INV[1];
      addr_o   = ~addr_o;
      data_o   = ~data_o;
   endtask
endmodule // dpbr_user_port

// File: verif/testbench.sv
// Self-checking bench for the dual-port RAM with a behavioural model.
`timescale 1ns/10ps
`include "dpbr_regs.vh"
module testbench;
   localparam [35:0] A_PRE  = 36'h987654321;
   localparam [35:0] B_INIT = 36'h5A5A5A5A5;
   localparam [35:0] B_PRE  = 36'h60F0F0F0F;
   logic        clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   wire         a_clk, a_gate, a_st, a_pre, b_clk, b_gate, b_st, b_pre;
   wire [13:0]  a_addr, b_addr;
   wire [35:0]  a_d, b_d;
   wire [31:0]  a_word, b_word;
   wire [3:0]   a_par, b_par;
   logic [35:0] mem [0:15];
   logic [35:0] expv [0:1];
   wire         c_clk, c_gate, c_st, c_pre, d_clk, d_gate, d_st, d_pre;
   wire [13:0]  c_addr, d_addr;
   wire [35:0]  c_d, d_d;
   wire [31:0]  c_word, d_word;
   wire [3:0]   c_par, d_par;
   logic [35:0] mem2 [0:15];
   logic [35:0] expv2 [0:1];
   integer      errors = 0;
   integer      checks = 0;
   integer      i;
   integer      seed;

   always #4 clk_i = ~clk_i;

   dpbr_user_port #(.INV(4'h0)) u_user_a (.clk_i(clk_i), .pclk_o(a_clk),
      .gate_o(a_gate), .strobe_o(a_st), .preset_o(a_pre), .addr_o(a_addr),
      .data_o(a_d));
   // Port B: falling active edge and active-low gate
   dpbr_user_port #(.INV(4'h3)) u_user_b (.clk_i(clk_i), .pclk_o(b_clk),
      .gate_o(b_gate), .strobe_o(b_st), .preset_o(b_pre), .addr_o(b_addr),
      .data_o(b_d));
   // Users of the width-converting instance, plain polarity
   dpbr_user_port #(.INV(4'h0)) u_user_c (.clk_i(clk_i), .pclk_o(c_clk),
      .gate_o(c_gate), .strobe_o(c_st), .preset_o(c_pre), .addr_o(c_addr),
      .data_o(c_d));
   dpbr_user_port #(.INV(4'h0)) u_user_d (.clk_i(clk_i), .pclk_o(d_clk),
      .gate_o(d_gate), .strobe_o(d_st), .preset_o(d_pre), .addr_o(d_addr),
      .data_o(d_d));

   dpbr_top
   #(
      .PORT_A_MODE(`DPBR_MODE_OLD_DATA),
      .PORT_B_MODE(`DPBR_MODE_HOLD),
      .PORT_B_INVERT(4'h3),
      .PORT_B_INIT_VALUE(B_INIT),
      .PORT_A_PRESET_VALUE(A_PRE),
      .PORT_B_PRESET_VALUE(B_PRE)
   )
   u_dut
   (
      .clk_i(clk_i), .reset_n_i(reset_n_i),
      .port_a_clk_i(a_clk), .port_a_gate(a_gate),
      .port_a_store_strobe(a_st), .port_a_sync_output_preset_i(a_pre),
      .port_a_addr_i(a_addr), .port_a_write_in_word_i(a_d[31:0]),
      .port_a_write_in_parity_i(a_d[35:32]),
      .port_a_read_word_o(a_word), .port_a_read_parity_o(a_par),
      .port_b_clk_i(b_clk), .port_b_gate(b_gate),
      .port_b_store_strobe(b_st), .port_b_sync_output_preset_i(b_pre),
      .port_b_addr_i(b_addr), .port_b_write_in_word_i(b_d[31:0]),
      .port_b_write_in_parity_i(b_d[35:32]),
      .port_b_read_word_o(b_word), .port_b_read_parity_o(b_par)
   );

   // Width conversion: port A at 18 bits and
   // port B at 9 bits; both pass-new
   dpbr_top
   #(
      .PORT_A_WIDTH(18),
      .PORT_B_WIDTH(9),
      .PORT_A_MODE(`DPBR_MODE_PASS_NEW),
      .PORT_B_MODE(`DPBR_MODE_PASS_NEW)
   )
   u_dut_conv
   (
      .clk_i(clk_i), .reset_n_i(reset_n_i),
      .port_a_clk_i(c_clk), .port_a_gate(c_gate),
      .port_a_store_strobe(c_st), .port_a_sync_output_preset_i(c_pre),
      .port_a_addr_i(c_addr), .port_a_write_in_word_i(c_d[31:0]),
      .port_a_write_in_parity_i(c_d[35:32]),
      .port_a_read_word_o(c_word), .port_a_read_parity_o(c_par),
      .port_b_clk_i(d_clk), .port_b_gate(d_gate),
      .port_b_store_strobe(d_st), .port_b_sync_output_preset_i(d_pre),
      .port_b_addr_i(d_addr), .port_b_write_in_word_i(d_d[31:0]),
      .port_b_write_in_parity_i(d_d[35:32]),
      .port_b_read_word_o(d_word), .port_b_read_parity_o(d_par)
   );

   task check(input string n, input logic [35:0] s, e);
      checks = checks + 1;
      if (s !== e)
      begin
         errors = errors + 1;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask

   // One access on one port, then the model and both outputs compared
   task op(input integer p, input logic en, we, pre,
           input logic [3:0] idx, input logic [35:0] d);
      logic [35:0] old;
      if (p == 0) u_user_a.access(en, we, pre, {10'h000, idx}, d);
      else u_user_b.access(en, we, pre, {10'h000, idx}, d);
      old = mem[idx];
      if (en)
      begin
         if (we) mem[idx] = d;
         if (pre) expv[p] = p ? B_PRE : A_PRE;
         else if (!we || p == 0) expv[p] = old;
      end // Gate off, or a hold-mode write, keeps the output
      check("port_a_out", {a_par, a_word}, expv[0]);
      check("port_b_out", {b_par, b_word}, expv[1]);
   endtask

   // One enabled access on the converting instance; the model keeps
   // data lanes low bits first and parity lanes above bit 32
   task op2(input integer p, input logic we, input logic [4:0] a,
            input logic [35:0] d);
      integer      dw, pw, ln, wd, k;
      logic [35:0] got;
      dw = p ? 8 : 16;
      pw = p ? 1 : 2;
      ln = a % (32 / dw);
      wd = a / (32 / dw);
      got = 36'h000000000;
      if (p == 0) u_user_c.access(1'b1, we, 1'b0, {9'h000, a}, d);
      else u_user_d.access(1'b1, we, 1'b0, {9'h000, a}, d);
      for (k = 0; k < dw; k = k + 1)
      begin
         if (we) mem2[wd][ln*dw+k] = d[k];
         got[k] = mem2[wd][ln*dw+k];
      end
      for (k = 0; k < pw; k = k + 1)
      begin
         if (we) mem2[wd][32+ln*pw+k] = d[32+k];
         got[32+k] = mem2[wd][32+ln*pw+k];
      end
      expv2[p] = got; // Pass-new shows the lane just written
      check("conv_a_out", {c_par, c_word}, expv2[0]);
      check("conv_b_out", {d_par, d_word}, expv2[1]);
   endtask

   task complete_run;
      if (errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence: reset, directed cases, then a random mix
   initial
   begin
      seed = $urandom(32'h4D89889C);
      for (i = 0; i < 16; i = i + 1) mem[i] = 36'h000000000;
      for (i = 0; i < 16; i = i + 1) mem2[i] = 36'h000000000;
      expv2[0] = 36'h000000000;
      expv2[1] = 36'h000000000;
      expv[0] = 36'h000000000;
      expv[1] = B_INIT;
      repeat (6) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (4) @(negedge clk_i);
      check("port_a_init", {a_par, a_word}, expv[0]);
      check("port_b_init", {b_par, b_word}, expv[1]);
      op(0, 1, 1, 0, 4'h3, 36'hF11112222);
      op(1, 1, 0, 0, 4'h3, 36'h000000000);
      op(1, 1, 1, 0, 4'h3, 36'h3CAFE0001);
      op(0, 0, 1, 0, 4'h3, 36'hBAD0BAD00);
      op(0, 1, 0, 0, 4'h3, 36'h000000000);
      op(0, 1, 1, 1, 4'h5, 36'h7DEADBEEF);
      op(1, 1, 0, 1, 4'h5, 36'h000000000);
      op(1, 1, 0, 0, 4'h5, 36'h000000000);
      op2(0, 1, 5'h03, 36'h20000A55A);
      op2(1, 0, 5'h06, 36'h000000000);
      op2(1, 0, 5'h07, 36'h000000000);
      op2(1, 1, 5'h04, 36'h1000000C3);
      op2(0, 0, 5'h02, 36'h000000000);
      for (i = 0; i < 20; i = i + 1)
         op2($urandom % 2, 1'($urandom), 5'($urandom),
             {4'($urandom), $urandom});
      // One port at a time, so no cell is hit from both sides
      for (i = 0; i < 60; i = i + 1)
         op($urandom % 2, ($urandom % 4) != 0, 1'($urandom),
            ($urandom % 5) == 0, 4'($urandom), {4'($urandom), $urandom});
      complete_run;
   end

   // Watchdog: about 95 accesses of 9 cycles need far less than this
   initial
   begin
      #40000;
      errors = errors + 1;
      complete_run;
   end
endmodule // testbench
